//--- design/oms_pkg.sv
// package of constants and types for the operating mode supervisor
package oms_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 40_000_000; // system clock rate
	localparam int unsigned FS_DWELL_MS = 100; // failsafe dwell time in ms
	localparam int unsigned OT_DELAY_MS = 1000; // overtemp restart delay in ms
	// cycle counts, plain products, cycles per ms exact at 40 MHz
	localparam int unsigned FS_DWELL_CYC = (CLK_FREQ_HZ / 1000) * FS_DWELL_MS;
	localparam int unsigned OT_DELAY_CYC = (CLK_FREQ_HZ / 1000) * OT_DELAY_MS;
	localparam int unsigned TMR_W = 26; // wide enough for one second

	// ----------------------------------------------------------------
	// mode field encodings of the mode command
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_CMD_NORMAL = 2'h0;
	localparam logic [1:0] MODE_CMD_SLEEP = 2'h1;
	localparam logic [1:0] MODE_CMD_STOP = 2'h2;
	localparam logic [1:0] MODE_CMD_SOFT_RESET = 2'h3;

	// cyclic timer source selections
	localparam logic [1:0] TSRC_FIRST_TIMER = 2'h0;
	localparam logic [1:0] TSRC_SECOND_TIMER = 2'h1;
	localparam logic [1:0] TSRC_SYNC_WAKE = 2'h2;

	// can transceiver states
	localparam logic [1:0] CAN_OFF = 2'h0;
	localparam logic [1:0] CAN_WAKE_CAP = 2'h1;
	localparam logic [1:0] CAN_ON = 2'h2;
	localparam logic [1:0] CAN_WOKEN = 2'h3;

	// operating modes, one hot
	typedef enum logic [5:0] {
		OMS_INIT = 6'b00_0001,
		OMS_NORMAL = 6'b00_0010,
		OMS_STOP = 6'b00_0100,
		OMS_SLEEP = 6'b00_1000,
		OMS_RESTART = 6'b01_0000,
		OMS_FAILSAFE = 6'b10_0000
	} oms_mode_type;

endpackage

//--- design/oms_sync.sv
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module oms_sync (
	input wire logic clk,
	input wire logic resetn,
	input wire logic pin_in,
	output logic level_out
);
	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	logic s1_r; // first stage, read only by s2
	logic s2_r;
	logic s3_r;
	logic lvl_r; // accepted level
	logic lvl_nxt;

	// accept a change only when stages two and three agree
	always_comb begin
		lvl_nxt = lvl_r;
		if (s2_r == s3_r) begin
			lvl_nxt = s3_r;
		end
	end

	// registers only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule // oms_sync

//--- design/oms_timer.sv
// down counter that signals expiry after a loadable number of cycles
`timescale 1ns/1ps
module oms_timer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic start,
	input wire logic [25:0] load_val,
	output logic expired
);
	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	logic [25:0] cnt_r; // cycles left
	logic [25:0] cnt_nxt;
	logic run_r; // counting
	logic run_nxt;

	// restart on start, otherwise count down to zero
	always_comb begin
		cnt_nxt = cnt_r;
		run_nxt = run_r;
		if (start) begin
			cnt_nxt = load_val;
			run_nxt = 1'b1;
		end else if (run_r && cnt_r != 26'h000_0000) begin
			cnt_nxt = cnt_r - 26'h000_0001;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 26'h000_0000;
			run_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			run_r <= run_nxt;
		end
	end

	// level while counted out and not restarting
	assign expired = run_r && (cnt_r == 26'h000_0000) && !start;
endmodule // oms_timer

//--- design/oms_supervisor.sv
// operating mode supervisor: mode state and per-function enables
//
// Functional notes
// - normal: regulator on, functions software controlled
// - normal: cyclic sense source selectable
// - normal: cyclic wake uses timer one/two
// - stop: regulator on in low power
// - stop: filter writes, flag spi error
// - stop: wakes raise interrupt, no mode change
// - stop: configs held, bridge/pump off
// - stop/sleep: low-side stages still allowed
// - sleep: regulator, watchdog, bridge off
// - reset output low during restart
// - restart: functions off, regulator on
// - restart: can woken, wake-capable or off
// - failsafe: everything off, can wake-capable
// - failsafe entry: arm wakes, clear flags
// - failsafe entry: drive fail output if configured
// - failsafe: 100ms dwell, stored wakes restart
// - overtemp: restart after cool plus 1s
// - failsafe entry disables parking braking
// - soft reset returns init, reloads registers
// - stop to sleep rejected, error, restart
`timescale 1ns/1ps
module oms_supervisor
	import oms_pkg::*;
#(
	parameter int unsigned FS_DWELL = FS_DWELL_CYC, // failsafe dwell cycles
	parameter int unsigned OT_DELAY = OT_DELAY_CYC // overtemp restart cycles
) (
	input wire logic clk,
	input wire logic resetn,
	// spi command decoded by the spi front end
	input wire logic cmd_valid,
	input wire logic cmd_is_write,
	input wire logic cmd_is_mode,
	input wire logic [1:0] cmd_mode,
	input wire logic cmd_is_wd_refresh,
	input wire logic cmd_is_status_access,
	output logic cmd_accept,
	output logic spi_error_set,
	output logic soft_reset_load,
	// failure entries from supervision
	input wire logic fail_to_restart,
	input wire logic fail_to_failsafe,
	// software configuration bits
	input wire logic cfg_watchdog_unit,
	input wire logic cfg_high_side_switches,
	input wire logic cfg_bridge_drivers,
	input wire logic [1:0] cfg_can,
	input wire logic cfg_cyc_sense,
	input wire logic [1:0] cfg_sense_src,
	input wire logic cfg_cyc_wake,
	input wire logic cfg_wake_src,
	input wire logic cfg_wk2_is_fail_out,
	input wire logic lowside_request,
	// pins and analog flags from outside the clock domain
	input wire logic can_wake_pin,
	input wire logic wake_inputs_pin,
	input wire logic regulator_overtemp_shutdown,
	input wire logic lowside_short_evt,
	input wire logic ov_brake_evt,
	// outputs
	output logic main_regulator_en,
	output logic main_regulator_lowpwr,
	output logic watchdog_unit_en,
	output logic high_side_switches_en,
	output logic bridge_drivers_en,
	output logic charge_pump_unit_en,
	output logic lowside_stage_en,
	output logic [1:0] can_state,
	output logic cyc_sense_en,
	output logic [1:0] cyc_sense_src,
	output logic cyc_wake_en,
	output logic cyc_wake_src,
	output logic cfg_hold,
	output logic wake_src_arm,
	output logic wake_flags_clear,
	output logic fail_output_pin,
	output logic parking_brake_disable,
	output logic stop_event_irq,
	output logic reset_out_n,
	output oms_mode_type mode
);
	// ----------------------------------------------------------------
	// synchronised inputs
	// ----------------------------------------------------------------
	logic can_wake_s; // bus wake level
	logic wk_s; // wake inputs level
	logic ot_s; // overtemp level
	logic ls_s; // low-side short
	logic ovb_s; // overvoltage brake

	oms_sync u_sync_can (.clk(clk), .resetn(resetn), .pin_in(can_wake_pin),
		.level_out(can_wake_s));
	oms_sync u_sync_wk (.clk(clk), .resetn(resetn), .pin_in(wake_inputs_pin),
		.level_out(wk_s));
	oms_sync u_sync_ot (.clk(clk), .resetn(resetn), .pin_in(regulator_overtemp_shutdown),
		.level_out(ot_s));
	oms_sync u_sync_ls (.clk(clk), .resetn(resetn), .pin_in(lowside_short_evt),
		.level_out(ls_s));
	oms_sync u_sync_ovb (.clk(clk), .resetn(resetn), .pin_in(ov_brake_evt),
		.level_out(ovb_s));

	// ----------------------------------------------------------------
	// mode state
	// ----------------------------------------------------------------
	oms_mode_type mode_r; // current operating mode
	oms_mode_type mode_nxt;
	logic wake_store_r; // wake seen in failsafe
	logic wake_store_nxt;
	logic ot_seen_r; // failsafe entered by overtemp
	logic ot_seen_nxt;
	logic can_woken_r; // bus wake in restart
	logic can_woken_nxt;
	logic fs_entry; // one cycle on failsafe entry
	logic fs_start; // dwell timer start
	logic ot_start; // overtemp filter start
	logic dwell_done;
	logic ot_done;
	logic ot_cool_r; // previous overtemp level
	logic wake_any;
	logic write_ok; // write allowed in stop

	assign wake_any = can_wake_s | wk_s;

	// dwell timer, restarted at every failsafe entry
	oms_timer u_dwell (.clk(clk), .resetn(resetn), .start(fs_start),
		.load_val(26'(FS_DWELL)), .expired(dwell_done));
	// overtemp filter restarts on the cooling edge
	oms_timer u_otf (.clk(clk), .resetn(resetn), .start(ot_start),
		.load_val(26'(OT_DELAY)), .expired(ot_done));

	assign write_ok = cmd_is_status_access || cmd_is_wd_refresh ||
		(cmd_is_mode && (cmd_mode == MODE_CMD_NORMAL || cmd_mode == MODE_CMD_SOFT_RESET));

	// next mode and command answer
	always_comb begin
		mode_nxt = mode_r;
		wake_store_nxt = wake_store_r;
		ot_seen_nxt = ot_seen_r;
		can_woken_nxt = can_woken_r;
		spi_error_set = 1'b0;
		soft_reset_load = 1'b0;
		cmd_accept = 1'b0;
		fs_entry = 1'b0;
		case (mode_r)
			OMS_INIT: begin
				// any command leaves init
				if (cmd_valid) begin
					cmd_accept = 1'b1;
					mode_nxt = OMS_NORMAL;
					if (cmd_is_mode && cmd_mode == MODE_CMD_SLEEP) begin
						spi_error_set = 1'b1;
					end
				end
			end
			OMS_NORMAL: begin
				if (cmd_valid) begin
					cmd_accept = 1'b1;
					if (cmd_is_write && cmd_is_mode) begin
						case (cmd_mode)
							MODE_CMD_STOP: mode_nxt = OMS_STOP;
							MODE_CMD_SLEEP: mode_nxt = OMS_SLEEP;
							MODE_CMD_SOFT_RESET: begin
								mode_nxt = OMS_INIT;
								soft_reset_load = 1'b1;
							end
							default: mode_nxt = OMS_NORMAL;
						endcase
					end
				end
			end
			OMS_STOP: begin
				if (cmd_valid) begin
					if (cmd_is_write && cmd_is_mode && cmd_mode == MODE_CMD_SLEEP) begin
						spi_error_set = 1'b1;
						mode_nxt = OMS_RESTART;
					end else if (cmd_is_write && !write_ok) begin
						spi_error_set = 1'b1;
					end else begin
						cmd_accept = 1'b1;
						if (cmd_is_write && cmd_is_mode && cmd_mode == MODE_CMD_NORMAL) begin
							mode_nxt = OMS_NORMAL;
						end else if (cmd_is_write && cmd_is_mode &&
							cmd_mode == MODE_CMD_SOFT_RESET) begin
							mode_nxt = OMS_INIT;
							soft_reset_load = 1'b1;
						end
					end
				end
			end
			OMS_SLEEP: begin
				if (can_wake_s) begin
					can_woken_nxt = 1'b1;
				end
				// wake leaves sleep through restart
				if (wake_any) begin
					mode_nxt = OMS_RESTART;
				end
			end
			OMS_RESTART: begin
				if (can_wake_s) begin
					can_woken_nxt = 1'b1;
				end
				if (cmd_valid) begin
					cmd_accept = 1'b1;
				end
				if (!fail_to_restart) begin
					mode_nxt = OMS_NORMAL;
					can_woken_nxt = 1'b0;
				end
			end
			OMS_FAILSAFE: begin
				if (can_wake_s) begin
					can_woken_nxt = 1'b1;
				end
				if (wake_any) begin
					wake_store_nxt = 1'b1;
				end
				if (dwell_done && (wake_store_r || wake_any)) begin
					mode_nxt = OMS_RESTART;
					wake_store_nxt = 1'b0;
					ot_seen_nxt = 1'b0;
				end else if (ot_seen_r && ot_done && !ot_s) begin
					mode_nxt = OMS_RESTART;
					ot_seen_nxt = 1'b0;
				end
			end
			default: mode_nxt = OMS_INIT;
		endcase
		// failures override command outcome, failsafe first
		if (fail_to_failsafe || ot_s) begin
			if (mode_r != OMS_FAILSAFE) begin
				fs_entry = 1'b1;
				wake_store_nxt = 1'b0;
				can_woken_nxt = 1'b0;
			end
			if (ot_s) begin
				ot_seen_nxt = 1'b1;
			end
			mode_nxt = OMS_FAILSAFE;
		end else if (fail_to_restart && mode_r != OMS_FAILSAFE && mode_r != OMS_INIT) begin
			mode_nxt = OMS_RESTART;
		end
	end

	assign fs_start = fs_entry;
	// cooling edge start
	// only the falling overtemp level loads the filter, so a hot spell never counts
	assign ot_start = ot_seen_r && ot_cool_r && !ot_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_r <= OMS_INIT;
			wake_store_r <= 1'b0;
			ot_seen_r <= 1'b0;
			can_woken_r <= 1'b0;
			ot_cool_r <= 1'b0;
		end else begin
			mode_r <= mode_nxt;
			wake_store_r <= wake_store_nxt;
			ot_seen_r <= ot_seen_nxt;
			can_woken_r <= can_woken_nxt;
			ot_cool_r <= ot_s;
		end
	end

	// ----------------------------------------------------------------
	// per-function decode
	// ----------------------------------------------------------------
	logic in_norm; // configurable
	logic in_hold; // stop or sleep
	assign in_norm = mode_r == OMS_NORMAL;
	assign in_hold = mode_r == OMS_STOP || mode_r == OMS_SLEEP;

	assign main_regulator_en = mode_r != OMS_SLEEP && mode_r != OMS_FAILSAFE;
	assign main_regulator_lowpwr = mode_r == OMS_STOP;
	assign watchdog_unit_en = (in_norm || mode_r == OMS_STOP) && cfg_watchdog_unit;
	assign high_side_switches_en = (in_norm || in_hold) && cfg_high_side_switches;
	// bridge and pump in normal only
	assign bridge_drivers_en = in_norm && cfg_bridge_drivers;
	assign charge_pump_unit_en = in_norm && cfg_bridge_drivers;
	assign lowside_stage_en = (in_norm || in_hold) && lowside_request;
	assign cyc_sense_en = (in_norm || in_hold) && cfg_cyc_sense;
	assign cyc_sense_src = cfg_sense_src;
	assign cyc_wake_en = (in_norm || in_hold) && cfg_cyc_wake;
	assign cyc_wake_src = cfg_wake_src;
	assign cfg_hold = in_hold;
	assign wake_src_arm = mode_r == OMS_FAILSAFE;
	assign wake_flags_clear = fs_entry;
	assign fail_output_pin = mode_r == OMS_FAILSAFE && cfg_wk2_is_fail_out;
	assign parking_brake_disable = mode_r == OMS_FAILSAFE;
	assign stop_event_irq = mode_r == OMS_STOP && (wake_any || ls_s || ovb_s);
	assign reset_out_n = mode_r != OMS_RESTART;
	assign mode = mode_r;

	always_comb begin
		case (mode_r)
			OMS_NORMAL: can_state = cfg_can;
			OMS_STOP: can_state = cfg_can;
			OMS_SLEEP: can_state = (cfg_can == CAN_OFF) ? CAN_OFF : CAN_WAKE_CAP;
			OMS_RESTART: can_state = can_woken_r ? CAN_WOKEN :
				((cfg_can == CAN_OFF) ? CAN_OFF : CAN_WAKE_CAP);
			OMS_FAILSAFE: can_state = CAN_WAKE_CAP;
			default: can_state = CAN_OFF;
		endcase
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_reset_restart: assert property ((mode_r == OMS_SLEEP && wake_any &&
		!fail_to_failsafe && !ot_s) |=> !reset_out_n)
		else $error("reset output not low after sleep wake");
	a_stop_filter: assert property ((mode_r == OMS_STOP && cmd_valid && cmd_is_write &&
		!write_ok && !(cmd_is_mode && cmd_mode == MODE_CMD_SLEEP) && !fail_to_failsafe &&
		!ot_s && !fail_to_restart) |=> mode_r == OMS_STOP)
		else $error("stop write not filtered");
	a_stop_sleep: assert property ((mode_r == OMS_STOP && cmd_valid && cmd_is_write &&
		cmd_is_mode && cmd_mode == MODE_CMD_SLEEP) |-> spi_error_set)
		else $error("stop to sleep not flagged");
	a_fs_bridge_off: assert property (mode_r == OMS_FAILSAFE |-> !bridge_drivers_en &&
		!main_regulator_en && can_state == CAN_WAKE_CAP)
		else $error("failsafe outputs wrong");
	a_soft_reset: assert property ((mode_r == OMS_NORMAL && cmd_valid && cmd_is_write &&
		cmd_is_mode && cmd_mode == MODE_CMD_SOFT_RESET && !fail_to_failsafe && !ot_s &&
		!fail_to_restart) |=> mode_r == OMS_INIT)
		else $error("soft reset did not reach init");
	a_fs_entry_clear: assert property ((mode_r != OMS_FAILSAFE) ##1
		(mode_r == OMS_FAILSAFE) |-> $past(wake_flags_clear))
		else $error("wake flags not cleared on failsafe entry");
	a_stop_lowpwr: assert property (mode_r == OMS_STOP |-> main_regulator_en &&
		main_regulator_lowpwr && !charge_pump_unit_en)
		else $error("stop regulator state wrong");
	a_sleep_off: assert property (mode_r == OMS_SLEEP |-> !watchdog_unit_en &&
		!main_regulator_en)
		else $error("sleep functions not off");

	c_stop_entry: cover property (mode_r == OMS_NORMAL ##1 mode_r == OMS_STOP);
	c_fs_restart: cover property (mode_r == OMS_FAILSAFE ##1 mode_r == OMS_RESTART);
	c_soft_reset: cover property (soft_reset_load);
endmodule // oms_supervisor

//--- testbench/oms_host_model.sv
// host controller model that issues decoded mode and register commands
`timescale 1ns/1ps
module oms_host_model (
	input wire logic clk,
	input wire logic reset_out_n,
	output logic cmd_valid,
	output logic cmd_is_write,
	output logic cmd_is_mode,
	output logic [1:0] cmd_mode,
	output logic cmd_is_wd_refresh,
	output logic cmd_is_status_access
);
	// fields packed as write, mode flag, mode code, refresh, status
	logic [5:0] fld;

	assign {cmd_is_write, cmd_is_mode, cmd_mode, cmd_is_wd_refresh, cmd_is_status_access} = fld;

	initial begin
		cmd_valid = 1'b0;
		fld = 6'h2a;
	end

	// one command, held for exactly one taking edge
	task automatic send(input logic [5:0] f);
		@(posedge clk);
		// host stays silent while held in reset
		while (reset_out_n !== 1'b1) begin
			@(posedge clk);
		end
		// only the commands the bench orders, refusals included
		cmd_valid <= 1'b1;
		fld <= f;
		@(posedge clk);
		cmd_valid <= 1'b0;
		// idle fields flip so a stale value is never trusted
		fld <= ~f;
	endtask
endmodule // oms_host_model

//--- testbench/oms_supervisor_test.sv
// self-checking bench of the operating mode supervisor
`timescale 1ns/1ps
module oms_supervisor_test;
	import oms_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int FSD = 20; // shortened dwell
	localparam int OTD = 50; // shortened overtemp filter
	logic clk, resetn, cmd_valid, cmd_is_write, cmd_is_mode, cmd_is_wd_refresh;
	logic cmd_is_status_access, cmd_accept, spi_error_set, soft_reset_load;
	logic [1:0] cmd_mode, cfg_can, cfg_sense_src, can_state, cyc_sense_src;
	logic fail_to_restart, fail_to_failsafe, cfg_watchdog_unit, cfg_high_side_switches;
	logic cfg_bridge_drivers, cfg_cyc_sense, cfg_cyc_wake, cfg_wake_src, cfg_wk2_is_fail_out;
	logic lowside_request, overtemp, main_regulator_en, main_regulator_lowpwr;
	logic watchdog_unit_en, high_side_switches_en, bridge_drivers_en, charge_pump_unit_en;
	logic lowside_stage_en, cyc_sense_en, cyc_wake_en, cyc_wake_src, cfg_hold, wake_src_arm;
	logic wake_flags_clear, fail_output_pin, parking_brake_disable, stop_event_irq, reset_out_n;
	logic [3:0] ev; // can wake, wake inputs, low-side short, brake event
	logic [2:0] note; // accept, error, reload
	logic [2:0] notes[$];
	oms_mode_type mode;
	int num_errors = 0, comparisons = 0, cyc = 0, i, n;

	oms_supervisor #(.FS_DWELL(FSD), .OT_DELAY(OTD)) u_oms_supervisor (.clk(clk),
		.resetn(resetn), .cmd_valid(cmd_valid), .cmd_is_write(cmd_is_write),
		.cmd_is_mode(cmd_is_mode), .cmd_mode(cmd_mode), .cmd_is_wd_refresh(cmd_is_wd_refresh),
		.cmd_is_status_access(cmd_is_status_access), .cmd_accept(cmd_accept),
		.spi_error_set(spi_error_set), .soft_reset_load(soft_reset_load),
		.fail_to_restart(fail_to_restart), .fail_to_failsafe(fail_to_failsafe),
		.cfg_watchdog_unit(cfg_watchdog_unit), .cfg_high_side_switches(cfg_high_side_switches),
		.cfg_bridge_drivers(cfg_bridge_drivers), .cfg_can(cfg_can), .cfg_cyc_sense(cfg_cyc_sense),
		.cfg_sense_src(cfg_sense_src), .cfg_cyc_wake(cfg_cyc_wake), .cfg_wake_src(cfg_wake_src),
		.cfg_wk2_is_fail_out(cfg_wk2_is_fail_out), .lowside_request(lowside_request),
		.can_wake_pin(ev[0]), .wake_inputs_pin(ev[1]), .regulator_overtemp_shutdown(overtemp),
		.lowside_short_evt(ev[2]), .ov_brake_evt(ev[3]), .main_regulator_en(main_regulator_en),
		.main_regulator_lowpwr(main_regulator_lowpwr), .watchdog_unit_en(watchdog_unit_en),
		.high_side_switches_en(high_side_switches_en), .bridge_drivers_en(bridge_drivers_en),
		.charge_pump_unit_en(charge_pump_unit_en), .lowside_stage_en(lowside_stage_en),
		.can_state(can_state), .cyc_sense_en(cyc_sense_en), .cyc_sense_src(cyc_sense_src),
		.cyc_wake_en(cyc_wake_en), .cyc_wake_src(cyc_wake_src), .cfg_hold(cfg_hold),
		.wake_src_arm(wake_src_arm), .wake_flags_clear(wake_flags_clear),
		.fail_output_pin(fail_output_pin), .parking_brake_disable(parking_brake_disable),
		.stop_event_irq(stop_event_irq), .reset_out_n(reset_out_n), .mode(mode));

	oms_host_model u_oms_host_model (.clk(clk), .reset_out_n(reset_out_n),
		.cmd_valid(cmd_valid), .cmd_is_write(cmd_is_write), .cmd_is_mode(cmd_is_mode),
		.cmd_mode(cmd_mode), .cmd_is_wd_refresh(cmd_is_wd_refresh),
		.cmd_is_status_access(cmd_is_status_access));

	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			report_and_stop();
		end
	end

	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// note the expected answer, then let the host send it
	task automatic cmd(logic [5:0] f, logic [2:0] exp);
		notes.push_back(exp);
		u_oms_host_model.send(f);
	endtask

	task automatic wait_mode(oms_mode_type m, int lim, output int k);
		k = 0;
		while (mode !== m && k < lim) begin
			@(negedge clk);
			k++;
		end
		chk("mode", mode, m);
	endtask

	task automatic chk_off();
		chk("wd_en", watchdog_unit_en, 0);
		chk("hs_en", high_side_switches_en, 0);
		chk("bd_en", bridge_drivers_en, 0);
		chk("cp_en", charge_pump_unit_en, 0);
		chk("sense_en", cyc_sense_en, 0);
		chk("wake_en", cyc_wake_en, 0);
	endtask

	// answers stand for one cycle, so look mid-cycle
	always @(negedge clk) begin
		if (cmd_valid === 1'b1) begin
			note = (notes.size() > 0) ? notes.pop_front() : 3'bxxx;
			chk("accept", cmd_accept, note[2]);
			chk("spi_err", spi_error_set, note[1]);
			chk("reload", soft_reset_load, note[0]);
		end
	end

	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{resetn, fail_to_restart, fail_to_failsafe, lowside_request, overtemp, ev} = 9'h000;
		{cfg_watchdog_unit, cfg_high_side_switches, cfg_bridge_drivers, cfg_can} = 5'h00;
		{cfg_cyc_sense, cfg_sense_src, cfg_cyc_wake, cfg_wake_src, cfg_wk2_is_fail_out} = 6'h00;
		void'($urandom(13565));
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		chk("mode", mode, OMS_INIT);
		chk("rst_n", reset_out_n, 1);
		cmd(6'h30, 3'b100);
		// software settings pass through in normal
		for (i = 0; i < 6; i++) begin
			@(posedge clk);
			{cfg_watchdog_unit, cfg_high_side_switches, cfg_bridge_drivers} <= 3'($urandom);
			{cfg_cyc_sense, cfg_cyc_wake} <= 2'($urandom);
			cfg_can <= 2'($urandom_range(2));
			cfg_sense_src <= 2'(i % 3);
			cfg_wake_src <= i[0];
			@(negedge clk);
			chk("mode", mode, OMS_NORMAL);
			chk("reg", {main_regulator_en, main_regulator_lowpwr}, 2'b10);
			chk("wd_en", watchdog_unit_en, cfg_watchdog_unit);
			chk("hs_en", high_side_switches_en, cfg_high_side_switches);
			chk("bdcp", {bridge_drivers_en, charge_pump_unit_en}, {2{cfg_bridge_drivers}});
			chk("can", can_state, cfg_can);
			chk("sense", {cyc_sense_en, cyc_sense_src}, {cfg_cyc_sense, cfg_sense_src});
			chk("cwake", {cyc_wake_en, cyc_wake_src}, {cfg_cyc_wake, cfg_wake_src});
		end
		@(posedge clk);
		{cfg_watchdog_unit, cfg_high_side_switches, cfg_bridge_drivers, cfg_can} <= 5'h1d;
		{cfg_cyc_sense, cfg_cyc_wake, cfg_wk2_is_fail_out, lowside_request} <= 4'hf;
		// stop keeps settings, bridge and pump off
		cmd(6'h38, 3'b100);
		@(negedge clk);
		chk("mode", mode, OMS_STOP);
		chk("reg", {main_regulator_en, main_regulator_lowpwr}, 2'b11);
		chk("bdcp", {bridge_drivers_en, charge_pump_unit_en}, 2'b00);
		chk("held", {watchdog_unit_en, high_side_switches_en, cfg_hold}, 3'b111);
		chk("ls_en", lowside_stage_en, 1);
		// plain write refused, refresh and status allowed
		cmd(6'h20, 3'b010);
		cmd(6'h22, 3'b100);
		cmd(6'h21, 3'b100);
		// each event raises the interrupt, mode stays
		for (i = 0; i < 4; i++) begin
			@(posedge clk);
			ev <= 4'(1 << i);
			n = 0;
			@(negedge clk);
			while (stop_event_irq !== 1'b1 && n < 8) begin
				@(negedge clk);
				n++;
			end
			chk("irq", stop_event_irq, 1);
			chk("mode", mode, OMS_STOP);
			@(posedge clk);
			ev <= 4'h0;
			repeat (8) @(posedge clk);
			@(negedge clk);
			chk("irq_idle", stop_event_irq, 0);
		end
		// stop to sleep refused and forced into restart
		cmd(6'h34, 3'b010);
		fail_to_restart <= 1'b1;
		repeat (4) begin
			@(negedge clk);
			chk("mode", mode, OMS_RESTART);
			chk("rst_n", reset_out_n, 0);
			chk("reg_en", main_regulator_en, 1);
			chk_off();
			chk("can_on", can_state === CAN_ON, 0);
		end
		@(posedge clk);
		fail_to_restart <= 1'b0;
		wait_mode(OMS_NORMAL, 10, n);
		// soft reset from stop is exempt and reloads
		cmd(6'h38, 3'b100);
		cmd(6'h3c, 3'b101);
		@(negedge clk);
		chk("mode", mode, OMS_INIT);
		cmd(6'h30, 3'b100);
		// sleep turns off regulator, watchdog, bridge
		cmd(6'h34, 3'b100);
		@(negedge clk);
		chk("mode", mode, OMS_SLEEP);
		chk("off", {main_regulator_en, watchdog_unit_en, bridge_drivers_en}, 3'b000);
		chk("kept", {high_side_switches_en, cyc_sense_en, cyc_wake_en}, 3'b111);
		chk("can", can_state, CAN_WAKE_CAP);
		chk("ls_en", lowside_stage_en, 1);
		@(posedge clk);
		ev <= 4'h1;
		wait_mode(OMS_RESTART, 10, n);
		chk("can", can_state, CAN_WOKEN);
		@(posedge clk);
		ev <= 4'h0;
		wait_mode(OMS_NORMAL, 10, n);
		@(posedge clk);
		fail_to_failsafe <= 1'b1;
		@(negedge clk);
		chk("flag_clr", wake_flags_clear, 1);
		@(posedge clk);
		fail_to_failsafe <= 1'b0;
		@(negedge clk);
		chk("mode", mode, OMS_FAILSAFE);
		chk_off();
		chk("reg_en", main_regulator_en, 0);
		chk("can", can_state, CAN_WAKE_CAP);
		chk("arm", wake_src_arm, 1);
		chk("fail_out", fail_output_pin, 1);
		chk("pb_dis", parking_brake_disable, 1);
		// early wake is stored until the dwell ends
		@(posedge clk);
		ev <= 4'h2;
		repeat (6) @(posedge clk);
		ev <= 4'h0;
		wait_mode(OMS_RESTART, 40, n);
		chk("dwell", (n + 6 >= FSD - 2) && (n + 6 <= FSD + 8), 1);
		wait_mode(OMS_NORMAL, 10, n);
		// overtemp restart after cooling plus filter
		@(posedge clk);
		overtemp <= 1'b1;
		wait_mode(OMS_FAILSAFE, 10, n);
		repeat (30) @(negedge clk);
		chk("mode", mode, OMS_FAILSAFE);
		@(posedge clk);
		overtemp <= 1'b0;
		wait_mode(OMS_RESTART, 80, n);
		chk("ot_delay", (n >= OTD - 2) && (n <= OTD + 10), 1);
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule // oms_supervisor_test
